// ---- design/dfsp_pkg.sv ----
// Notes on behaviour
// - Otherwise pin is PWM from duty bits
// - Duty in 64ths; zero low, 63 max
// - Drive bit 7 picks clock with control bits
// - Control bit 2 doubles channel one rate
// - Control bit 3 doubles channel two rate
// - Two identical channels at 0x56, 0x57
// - Control bits 0,1 select channel clock source
package dfsp_pkg;
	localparam logic [7:0] ADDR_FAN_ONE = 8'h56;
	localparam logic [7:0] ADDR_FAN_TWO = 8'h57;
	localparam logic [7:0] ADDR_FAN_CTRL = 8'h58;
	localparam logic [7:0] RST_DRIVE = 8'h00;
	localparam logic [7:0] RST_FAN_CTRL = 8'h50;
	localparam int BIT_FULL_ON = 0;
	localparam int BIT_DUTY_LO = 1;
	localparam int BIT_DUTY_HI = 6;
	localparam int BIT_CLK_SEL = 7;
	localparam int BIT_SRC_ONE = 0;
	localparam int BIT_SRC_TWO = 1;
	localparam int BIT_DBL_ONE = 2;
	localparam int BIT_DBL_TWO = 3;
	localparam int DUTY_W = 6;
	localparam int RATE_SEL_W = 2;
	localparam int BASE_STEP_DIV = 4;

	typedef struct packed {
		logic full_on;
		logic [DUTY_W-1:0] duty;
	} dfsp_setting_t;

	typedef struct packed {
		logic [RATE_SEL_W-1:0] rate_sel;
		logic dbl;
	} dfsp_clk_t;
endpackage : dfsp_pkg

// ---- design/dfsp_channel.sv ----
`timescale 1ns/100ps
module dfsp_channel (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic step_in,
	input wire dfsp_pkg::dfsp_setting_t setting_in,
	output logic fan_out,
	output logic period_start_out
);
	logic [dfsp_pkg::DUTY_W-1:0] cnt_ff;
	logic [dfsp_pkg::DUTY_W-1:0] nxt_cnt;
	dfsp_pkg::dfsp_setting_t act_ff;
	dfsp_pkg::dfsp_setting_t nxt_act;
	logic pin_ff;
	logic nxt_pin;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_act = act_ff;
		nxt_pin = pin_ff;
		if (step_in) begin
			nxt_cnt = cnt_ff + 1'b1;
			if (&cnt_ff) begin
				nxt_act = setting_in;
			end
			if (nxt_act.full_on) begin
				nxt_pin = 1'b1;
			end else begin
				nxt_pin = (nxt_cnt < nxt_act.duty);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cnt_ff <= '1;
			act_ff <= '0;
			pin_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			act_ff <= nxt_act;
			pin_ff <= nxt_pin;
		end
	end

	assign fan_out = pin_ff;
	assign period_start_out = step_in && (&cnt_ff);
endmodule : dfsp_channel

// ---- design/dfsp_top.sv ----
`timescale 1ns/100ps
module dfsp_top #(
	parameter int BASE_DIV = 16,
	parameter int SLOW_DIV = 4,
	parameter int SRC_DIV = 2
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic first_fan_output_out,
	output logic second_fan_output_out
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] fan_one_drive_ff;
	logic [7:0] fan_two_drive_ff;
	logic [7:0] fan_ctrl_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_fan_one_drive;
	logic [7:0] nxt_fan_two_drive;
	logic [7:0] nxt_fan_ctrl;
	logic [7:0] nxt_rdata;

	always_comb begin
		nxt_fan_one_drive = fan_one_drive_ff;
		nxt_fan_two_drive = fan_two_drive_ff;
		nxt_fan_ctrl = fan_ctrl_ff;
		nxt_rdata = 8'h00;
		if (wr_in) begin
			case (addr_in)
				dfsp_pkg::ADDR_FAN_ONE: nxt_fan_one_drive = wdata_in;
				dfsp_pkg::ADDR_FAN_TWO: nxt_fan_two_drive = wdata_in;
				dfsp_pkg::ADDR_FAN_CTRL: nxt_fan_ctrl = wdata_in;
				default: nxt_fan_ctrl = fan_ctrl_ff;
			endcase
		end
		if (rd_in) begin
			case (addr_in)
				dfsp_pkg::ADDR_FAN_ONE: nxt_rdata = fan_one_drive_ff;
				dfsp_pkg::ADDR_FAN_TWO: nxt_rdata = fan_two_drive_ff;
				dfsp_pkg::ADDR_FAN_CTRL: nxt_rdata = fan_ctrl_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			fan_one_drive_ff <= dfsp_pkg::RST_DRIVE;
			fan_two_drive_ff <= dfsp_pkg::RST_DRIVE;
			fan_ctrl_ff <= dfsp_pkg::RST_FAN_CTRL;
			rdata_ff <= 8'h00;
		end else begin
			fan_one_drive_ff <= nxt_fan_one_drive;
			fan_two_drive_ff <= nxt_fan_two_drive;
			fan_ctrl_ff <= nxt_fan_ctrl;
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata_out = rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// Shared prescaler; each channel then divides further by its own selection
	logic [15:0] pre_ff;
	logic [15:0] nxt_pre;
	logic base_tick;

	always_comb begin
		base_tick = (pre_ff == 16'(BASE_DIV - 1));
		nxt_pre = base_tick ? 16'h0000 : pre_ff + 16'h0001;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pre_ff <= 16'h0000;
		end else begin
			pre_ff <= nxt_pre;
		end
	end

	////////////////////////////////////////////////////////////////////////
	dfsp_pkg::dfsp_clk_t clk_cfg [2];
	dfsp_pkg::dfsp_setting_t set_cfg [2];
	logic [1:0] fan_pin;

	always_comb begin
		clk_cfg[0].rate_sel = {fan_one_drive_ff[dfsp_pkg::BIT_CLK_SEL],
			fan_ctrl_ff[dfsp_pkg::BIT_SRC_ONE]};
		clk_cfg[0].dbl = fan_ctrl_ff[dfsp_pkg::BIT_DBL_ONE];
		clk_cfg[1].rate_sel = {fan_two_drive_ff[dfsp_pkg::BIT_CLK_SEL],
			fan_ctrl_ff[dfsp_pkg::BIT_SRC_TWO]};
		clk_cfg[1].dbl = fan_ctrl_ff[dfsp_pkg::BIT_DBL_TWO];
		set_cfg[0].full_on = fan_one_drive_ff[dfsp_pkg::BIT_FULL_ON];
		set_cfg[0].duty = fan_one_drive_ff[dfsp_pkg::BIT_DUTY_HI:dfsp_pkg::BIT_DUTY_LO];
		set_cfg[1].full_on = fan_two_drive_ff[dfsp_pkg::BIT_FULL_ON];
		set_cfg[1].duty = fan_two_drive_ff[dfsp_pkg::BIT_DUTY_HI:dfsp_pkg::BIT_DUTY_LO];
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic [15:0] div_ff;
			logic [15:0] nxt_div;
			logic [15:0] div_len;
			logic step;

			// Division: source 0 uses BASE_STEP_DIV, source 1 uses 2 x SRC_DIV, clock-select x SLOW_DIV, doubler halves
			always_comb begin
				div_len = 16'(dfsp_pkg::BASE_STEP_DIV);
				if (clk_cfg[g].rate_sel[0]) begin
					div_len = 16'(2 * SRC_DIV);
				end
				if (clk_cfg[g].rate_sel[1]) begin
					div_len = 16'(div_len * 16'(SLOW_DIV));
				end
				if (clk_cfg[g].dbl) begin
					div_len = div_len >> 1;
				end
				step = base_tick && (div_ff >= div_len - 16'h0001);
				nxt_div = div_ff;
				if (base_tick) begin
					nxt_div = step ? 16'h0000 : div_ff + 16'h0001;
				end
			end

			always_ff @(posedge clk_in) begin
				if (sys_rst_in) begin
					div_ff <= 16'h0000;
				end else begin
					div_ff <= nxt_div;
				end
			end

			dfsp_channel u_ch (
				.clk_in(clk_in),
				.sys_rst_in(sys_rst_in),
				.step_in(step),
				.setting_in(set_cfg[g]),
				.fan_out(fan_pin[g]),
				.period_start_out()
			);
		end
	endgenerate

	assign first_fan_output_out = fan_pin[0];
	assign second_fan_output_out = fan_pin[1];
endmodule : dfsp_top

// ---- testbench/dfsp_chk.sv ----
`timescale 1ns/100ps
module dfsp_chk (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic first_fan_output_out,
	input wire logic second_fan_output_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	logic [7:0] d1_ff;
	logic [10:0] age_ff;
	// Settle bound covers the slowest period plus the boundary wait
	always_ff @(posedge clk_in) begin
		d1_ff <= sys_rst_in ? 8'h00 : (wr_in && addr_in == 8'h56) ? wdata_in : d1_ff;
		age_ff <= (sys_rst_in || (wr_in && addr_in == 8'h56)) ? 11'h000 :
			age_ff + 11'(age_ff != 11'h7ff);
	end
	a_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("stray data");
	a_rd_single: assert property (rd_in ##1 !rd_in |=> rdata_out == 8'h00) else $error("held data");
	a_unmapped_zero: assert property (rd_in && (addr_in < 8'h56 || addr_in > 8'h58)
		|=> rdata_out == 8'h00) else $error("unmapped read");
	a_one_readback: assert property (wr_in && addr_in == 8'h56 ##1 rd_in && addr_in == 8'h56
		|=> rdata_out == $past(wdata_in, 2)) else $error("first drive readback");
	a_two_readback: assert property (wr_in && addr_in == 8'h57 ##1 rd_in && addr_in == 8'h57
		|=> rdata_out == $past(wdata_in, 2)) else $error("second drive readback");
	a_ctrl_readback: assert property (wr_in && addr_in == 8'h58 ##1 rd_in && addr_in == 8'h58
		|=> rdata_out == $past(wdata_in, 2)) else $error("control readback");
	a_full_on_high: assert property (age_ff > 11'h460 && d1_ff[0] |-> first_fan_output_out)
		else $error("full on not high");
	a_zero_low: assert property (age_ff > 11'h460 && d1_ff[6:0] == 7'h00
		|-> !first_fan_output_out) else $error("zero duty not low");
endmodule : dfsp_chk

// ---- testbench/dfsp_fan_model.sv ----
`timescale 1ns/100ps
module dfsp_fan_model (
	input wire logic clk_in,
	input wire logic pin_in,
	input wire logic clr_in,
	output int highs_out,
	output int rises_out
);
	logic last_ff = 1'b0;
	// Motor sees only averaged drive: high time and pulse count per window
	always_ff @(posedge clk_in) begin
		last_ff <= pin_in;
		highs_out <= clr_in ? 0 : highs_out + int'(pin_in);
		rises_out <= clr_in ? 0 : rises_out + int'(pin_in & ~last_ff);
	end
endmodule : dfsp_fan_model

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	typedef struct packed {logic [7:0] c, d1, d2; logic [3:0] r1, r2;} dfsp_row_t;
	logic clk_in = 1'b0, sys_rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, clr = 1'b0, f1, f2;
	logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
	int h1, h2, e1, e2, n_errors = 0, check_count = 0;
	dfsp_row_t rows [6] = '{'{8'h00, 8'h40, 8'h7e, 4'h2, 4'h2}, '{8'h08, 8'h01, 8'h02, 4'h0, 4'h4},
		'{8'h0c, 8'h00, 8'hc0, 4'h0, 4'h1}, '{8'h03, 8'h40, 8'h40, 4'h4, 4'h4},
		'{8'h07, 8'h3c, 8'h40, 4'h8, 4'h4}, '{8'h07, 8'hc2, 8'hbe, 4'h2, 4'h1}};
	dfsp_top #(.BASE_DIV(1), .SLOW_DIV(4), .SRC_DIV(1)) dfsp_top_i (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .first_fan_output_out(f1),
		.second_fan_output_out(f2));
	dfsp_fan_model m1 (.clk_in(clk_in), .pin_in(f1), .clr_in(clr), .highs_out(h1), .rises_out(e1));
	dfsp_fan_model m2 (.clk_in(clk_in), .pin_in(f2), .clr_in(clr), .highs_out(h2), .rises_out(e2));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
	endtask : wr
	task automatic rd(input logic [7:0] a, exp);
		addr_in <= a;
		rd_in <= 1'b1;
		wr_in <= 1'b0;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 chk("rdata", rdata_out, exp);
		@(posedge clk_in);
	endtask : rd
	function automatic logic [31:0] hi(input logic [7:0] d);
		return d[0] ? 512 : 32'(d[6:1]) * 8;
	endfunction : hi
	task automatic give_verdict;
		if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////////////////////
	initial forever #12.5 clk_in = ~clk_in;
	initial begin
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		foreach (rows[i]) begin
			wr(8'h58, rows[i].c);
			wr(8'h56, rows[i].d1);
			wr(8'h57, rows[i].d2);
			rd(8'h57, rows[i].d2);
			rd(8'h58, rows[i].c);
			// Two windows: one to reach a boundary, one exact measurement span
			repeat (1100) @(posedge clk_in);
			clr <= 1'b1;
			@(posedge clk_in);
			clr <= 1'b0;
			repeat (512) @(posedge clk_in);
			#1 chk("high1", h1, hi(rows[i].d1));
			chk("rise1", e1, rows[i].r1);
			chk("high2", h2, hi(rows[i].d2));
			chk("rise2", e2, rows[i].r2);
			@(posedge clk_in);
		end
		sys_rst_in <= 1'b1;
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		rd(8'h56, 8'h00);
		rd(8'h57, 8'h00);
		rd(8'h58, 8'h50);
		wr(8'h59, 8'hff);
		rd(8'h59, 8'h00);
		rd(8'h55, 8'h00);
		// Write then read at once, so the readback checks see their trigger
		wr(8'h56, 8'hab);
		rd(8'h56, 8'hab);
		wr(8'h57, 8'h5c);
		rd(8'h57, 8'h5c);
		wr(8'h58, 8'h3f);
		rd(8'h58, 8'h3f);
		give_verdict();
	end
endmodule : testbench
bind dfsp_top dfsp_chk dfsp_chk_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.first_fan_output_out(first_fan_output_out), .second_fan_output_out(second_fan_output_out));
